/* File: dv/converter_fault_supervisor_bench.sv */
// Purpose: Self-checking bench of the converter fault supervisor
// Assumes: Millisecond tick shortened to 10 cycles
// Notes:   Inputs change at the falling edge; checks sit a few cycles after pin changes
`include "fault_supervisor_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module converter_fault_supervisor_bench;
	import fault_supervisor_pkg::*;
	localparam int MS_CYCLES = 10;
	logic        core_clk, resetn, runRequest, sensorTempValid, sensorGrounded;
	logic        overvoltageFault, undervoltageFault, overvoltageWarn, undervoltageWarn;
	logic        cmdValid, cmdWrite, rspValid, switchEnable, lowSideOn, powerOkOe, alertOe;
	logic [7:0]  cmdCode;
	logic [15:0] cmdData, rspData, junctionTemp, sensorTemp, rd;
	logic [2:0]  pgHystMultiple;
	int          failures, num_checks;

	converter_fault_supervisor #(.MS_CYCLES(MS_CYCLES)) dut_u (
		.core_clk(core_clk), .resetn(resetn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
		.cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
		.runRequest(runRequest), .junctionTemp(junctionTemp), .sensorTemp(sensorTemp),
		.sensorTempValid(sensorTempValid), .sensorGrounded(sensorGrounded),
		.overvoltageFault(overvoltageFault), .undervoltageFault(undervoltageFault),
		.overvoltageWarn(overvoltageWarn), .undervoltageWarn(undervoltageWarn),
		.switchEnable(switchEnable), .lowSideOn(lowSideOn), .pgHystMultiple(pgHystMultiple),
		.powerOkOe(powerOkOe), .alertOe(alertOe)
	);
	pmbus_host_model host_u (
		.core_clk(core_clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
		.cmdData(cmdData), .rspValid(rspValid), .rspData(rspData)
	);

	task automatic ck(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : ck
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc
	task automatic sw(input logic e);
		ck("switchEnable", 16'(e), 16'(switchEnable));
	endtask : sw
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host_u.send(1'b1, c, d);
	endtask : wr
	task automatic rdck(input logic [7:0] c, input logic [15:0] exp);
		host_u.fetch(c, rd);
		ck($sformatf("register %h", c), exp, rd);
	endtask : rdck
	task automatic sample(input logic [15:0] t);
		@(negedge core_clk);
		sensorTemp = t;
		sensorTempValid = 1'b1;
		@(negedge core_clk);
		sensorTempValid = 1'b0;
		cyc(6);
	endtask : sample

	task automatic t_regs;
		rdck(`CMD_EXT_TEMP_FAULT_LIMIT, `RST_EXT_FAULT_LIMIT);
		rdck(`CMD_EXT_TEMP_WARN_LIMIT, `RST_EXT_WARN_LIMIT);
		rdck(`CMD_FAULT_ACTIONS, `RST_ACTIONS);
		rdck(8'h00, 16'h0000);
		sample(16'h0020);
		wr(`CMD_EXT_TEMP_READING, 16'h1234);
		rdck(`CMD_EXT_TEMP_READING, 16'h0020);
		wr(`CMD_OPTION_SETTINGS, 16'h0000);
		rdck(`CMD_EXT_TEMP_READING, `TEMP_SOFTSTART_MODE);
		wr(`CMD_OPTION_SETTINGS, `RST_OPTION_SETTINGS);
		sensorGrounded = 1'b1;
		sample(16'h0100);
		rdck(`CMD_EXT_TEMP_READING, `TEMP_GROUNDED);
		rdck(`CMD_TEMPERATURE_STATUS, 16'h0000);
		sensorGrounded = 1'b0;
		sample(16'h0020);
		for (int i = 0; i < 3; i++) begin
			wr(`CMD_SCALE_LOOP, 16'(i));
			cyc(2);
			ck("pgHystMultiple", 16'h1 << i, 16'(pgHystMultiple));
		end
		$display("registers done");
	endtask : t_regs

	task automatic t_power_good;
		runRequest = 1'b1;
		cyc(80);
		sw(1'b1);
		ck("powerOkOe", 16'h0, 16'(powerOkOe));
		overvoltageWarn = 1'b1;
		cyc(6);
		sw(1'b1);
		ck("powerOkOe", 16'h1, 16'(powerOkOe));
		overvoltageWarn = 1'b0;
		undervoltageWarn = 1'b1;
		cyc(6);
		sw(1'b1);
		ck("powerOkOe", 16'h1, 16'(powerOkOe));
		undervoltageWarn = 1'b0;
		cyc(6);
		ck("powerOkOe", 16'h0, 16'(powerOkOe));
		ck("alertOe", 16'h1, 16'(alertOe));
		rdck(`CMD_VENDOR_STATUS, 16'h0018);
		wr(`CMD_VENDOR_STATUS, 16'h0018);
		cyc(2);
		ck("alertOe", 16'h0, 16'(alertOe));
		$display("power good done");
	endtask : t_power_good

	task automatic t_thermal;
		junctionTemp = `SHUTDOWN_TEMPERATURE;
		cyc(6);
		sw(1'b1);
		junctionTemp = `SHUTDOWN_TEMPERATURE + 16'h0001;
		cyc(6);
		sw(1'b0);
		ck("alertOe", 16'h1, 16'(alertOe));
		junctionTemp = 16'h0080;
		cyc(80);
		sw(1'b0);
		junctionTemp = 16'h0019;
		cyc(80);
		sw(1'b1);
		rdck(`CMD_VENDOR_STATUS, 16'h0001);
		wr(`CMD_ALERT_MASK, 16'h0001);
		cyc(2);
		ck("alertOe", 16'h0, 16'(alertOe));
		wr(`CMD_VENDOR_STATUS, 16'h0001);
		wr(`CMD_ALERT_MASK, 16'h0000);
		$display("internal thermal done");
	endtask : t_thermal

	task automatic t_external;
		wr(`CMD_EXT_TEMP_FAULT_LIMIT, 16'h0050);
		wr(`CMD_EXT_TEMP_WARN_LIMIT, 16'h0040);
		sample(16'h0045);
		sw(1'b1);
		rdck(`CMD_TEMPERATURE_STATUS, 16'h0040);
		sample(16'h0051);
		sw(1'b0);
		rdck(`CMD_TEMPERATURE_STATUS, 16'h00C0);
		sample(16'h003E);
		cyc(80);
		sw(1'b0);
		sample(16'h0020);
		cyc(80);
		sw(1'b1);
		wr(`CMD_FAULT_ACTIONS, 16'h0016);
		sample(16'h0060);
		sw(1'b1);
		sample(16'h0020);
		wr(`CMD_FAULT_ACTIONS, 16'h0014);
		sample(16'h0060);
		sample(16'h0020);
		cyc(80);
		sw(1'b0);
		runRequest = 1'b0;
		cyc(4);
		runRequest = 1'b1;
		cyc(80);
		sw(1'b1);
		wr(`CMD_FAULT_ACTIONS, `RST_ACTIONS);
		wr(`CMD_TEMPERATURE_STATUS, 16'h00C0);
		$display("external thermal done");
	endtask : t_external

	task automatic t_overvoltage;
		overvoltageFault = 1'b1;
		cyc(6);
		ck("lowSideOn", 16'h1, 16'(lowSideOn));
		sw(1'b0);
		rdck(`CMD_VENDOR_STATUS, 16'h0002);
		overvoltageFault = 1'b0;
		undervoltageFault = 1'b1;
		cyc(6);
		ck("lowSideOn", 16'h0, 16'(lowSideOn));
		undervoltageFault = 1'b0;
		cyc(300);
		sw(1'b0);
		cyc(140);
		sw(1'b1);
		wr(`CMD_FAULT_ACTIONS, 16'h0019);
		overvoltageFault = 1'b1;
		cyc(6);
		sw(1'b1);
		ck("lowSideOn", 16'h0, 16'(lowSideOn));
		overvoltageFault = 1'b0;
		wr(`CMD_VENDOR_STATUS, 16'h003F);
		$display("overvoltage done");
	endtask : t_overvoltage

	task automatic t_undervoltage;
		wr(`CMD_FAULT_ACTIONS, 16'h0025);
		undervoltageFault = 1'b1;
		cyc(6);
		sw(1'b1);
		wr(`CMD_VENDOR_STATUS, 16'h003F);
		wr(`CMD_FAULT_ACTIONS, 16'h0005);
		cyc(6);
		sw(1'b0);
		ck("lowSideOn", 16'h0, 16'(lowSideOn));
		rdck(`CMD_VENDOR_STATUS, 16'h0004);
		undervoltageFault = 1'b0;
		cyc(400);
		sw(1'b0);
		runRequest = 1'b0;
		wr(`CMD_MAX_STARTUP_TIME, 16'h000A);
		wr(`CMD_VENDOR_STATUS, 16'h003F);
		undervoltageFault = 1'b1;
		runRequest = 1'b1;
		cyc(70);
		rdck(`CMD_VENDOR_STATUS, 16'h0000);
		cyc(60);
		rdck(`CMD_VENDOR_STATUS, 16'h0024);
		$display("undervoltage done");
	endtask : t_undervoltage

	task automatic give_verdict;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : give_verdict

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// The tests need under 2500 cycles; the limit allows 20000
	initial begin
		#100000;
		failures++;
		$display("watchdog expired");
		give_verdict();
	end

	initial begin
		resetn = 1'b0;
		runRequest = 1'b0;
		junctionTemp = 16'h0019;
		sensorTemp = 16'h0019;
		sensorTempValid = 1'b0;
		sensorGrounded = 1'b0;
		overvoltageFault = 1'b0;
		undervoltageFault = 1'b0;
		overvoltageWarn = 1'b0;
		undervoltageWarn = 1'b0;
		cyc(5);
		resetn = 1'b1;
		cyc(1);
		t_regs();
		t_power_good();
		t_thermal();
		t_external();
		t_overvoltage();
		t_undervoltage();
		give_verdict();
	end
endmodule : converter_fault_supervisor_bench

bind converter_fault_supervisor fault_supervisor_properties #(.MS_CYCLES(MS_CYCLES)) props_u (
	.core_clk(core_clk), .resetn(resetn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
	.cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
	.runRequest(runRequest), .junctionTemp(junctionTemp), .overvoltageWarn(overvoltageWarn),
	.switchEnable(switchEnable), .lowSideOn(lowSideOn), .pgHystMultiple(pgHystMultiple),
	.powerOkOe(powerOkOe)
);

`default_nettype wire

/* File: dv/fault_supervisor_properties.sv */
// Purpose: Port-level properties of the converter fault supervisor
// Assumes: Bound to the top module; one clock domain
// Notes:   Pin inputs pass two flip-flops, so pin causes get a few cycles of slack
`include "fault_supervisor_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module fault_supervisor_properties #(
	parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdData,
	input  wire logic        rspValid,
	input  wire logic [15:0] rspData,
	input  wire logic        runRequest,
	input  wire logic [15:0] junctionTemp,
	input  wire logic        overvoltageWarn,
	input  wire logic        switchEnable,
	input  wire logic        lowSideOn,
	input  wire logic [2:0]  pgHystMultiple,
	input  wire logic        powerOkOe
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_read_answer: assert property (cmdValid && !cmdWrite |=> rspValid)
		else $error("read command not answered");
	a_write_quiet: assert property (cmdValid && cmdWrite |=> !rspValid)
		else $error("write command answered");
	a_rsp_idle: assert property (!rspValid |-> rspData == 16'h0000)
		else $error("read data outside answer");
	a_discharge_excl: assert property (lowSideOn |-> !switchEnable)
		else $error("discharge while switching");
	a_discharge_pg: assert property (lowSideOn |-> powerOkOe)
		else $error("power good released in discharge");
	a_hot_stop: assert property ($signed(junctionTemp) > $signed(`SHUTDOWN_TEMPERATURE)
		|-> ##[1:4] !switchEnable)
		else $error("hot junction kept switching");
	a_hot_hold: assert property (!switchEnable
		&& $signed(junctionTemp) > $signed(`SHUTDOWN_TEMPERATURE)
		|=> !switchEnable)
		else $error("restart while junction hot");
	a_warn_pg: assert property (overvoltageWarn [*4] |-> powerOkOe)
		else $error("power good released under warning");
	a_hyst_half: assert property (cmdValid && cmdWrite && cmdCode == `CMD_SCALE_LOOP
		&& cmdData[1:0] == 2'h1 |-> ##[1:2] pgHystMultiple == 3'h2)
		else $error("hysteresis multiple not doubled");
	a_idle_off: assert property (!runRequest [*3] |-> !switchEnable)
		else $error("switching without run request");
endmodule : fault_supervisor_properties

`default_nettype wire

/* File: dv/pmbus_host_model.sv */
// Purpose: Management host issuing decoded commands to the supervisor
// Assumes: Requests launched at the falling edge of core_clk
// Notes:   Idle code and data lines are inverted so stale values never look valid
`timescale 1ns/100ps
`default_nettype none

module pmbus_host_model (
	input  wire logic        core_clk,
	output var  logic        cmdValid,
	output var  logic        cmdWrite,
	output var  logic [7:0]  cmdCode,
	output var  logic [15:0] cmdData,
	input  wire logic        rspValid,
	input  wire logic [15:0] rspData
);
	initial begin
		cmdValid = 1'b0;
		cmdWrite = 1'b0;
		cmdCode  = 8'h00;
		cmdData  = 16'h0000;
	end

	task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] data);
		@(negedge core_clk);
		cmdValid = 1'b1;
		cmdWrite = wr;
		cmdCode  = code;
		cmdData  = data;
		@(negedge core_clk);
		cmdValid = 1'b0;
		cmdCode  = ~cmdCode;
		cmdData  = ~cmdData;
	endtask : send

	task automatic fetch(input logic [7:0] code, output logic [15:0] data);
		int n;
		send(1'b0, code, 16'h0000);
		n = 0;
		while (rspValid !== 1'b1 && n < 3) begin
			@(negedge core_clk);
			n++;
		end
		data = (rspValid === 1'b1) ? rspData : 16'hXXXX;
	endtask : fetch
endmodule : pmbus_host_model

`default_nettype wire

/* File: hdl/converter_fault_supervisor.sv */
// Purpose: Fault supervision of a step-down converter: thermal, OV, UV, start-up, power good
// Assumes: Commands arrive decoded from the management link on core_clk; ADC words on core_clk
// Notes:   Comparator and strap pins are asynchronous and pass two flip-flops
//
// Contract
// RULE1: Junction above shutdown sets internal thermal flag
// RULE2: Stay stopped until junction cools by hysteresis
// RULE3: Internal thermal fault raises alert unless masked
// RULE4: Compare external temperature with fault, warn limits
// RULE5: External fault stops until cooled by hysteresis
// RULE6: Telemetry register tracks latest external sample
// RULE7: Host programs external fault and warn limits
// RULE8: External events set temperature flags and alert
// RULE9: Grounded sensor reads low, suppresses external faults
// RULE10: Soft-start pin mode reads constant temperature
// RULE11: Thermal response latch, restart or ignore
// RULE12: Overvoltage stops switching, low side discharges
// RULE13: Overvoltage flags, alerts, then hiccup or latch
// RULE14: Overvoltage ignore keeps regulating
// RULE15: Undervoltage after soft-start turns both switches off
// RULE16: Undervoltage sets flags and alert unless masked
// RULE17: Undervoltage ignore keeps running
// RULE18: Enforce programmable maximum start-up time
// RULE19: Start-up undervoltage deferred to maximum start time
// RULE20: Power good only inside warning window
// RULE21: Power-good hysteresis scales inversely with loop scale
// RULE22: Power good low on any fault; an undervoltage or an external over-temperature under the ignore action does not pull it low
// RULE23: Restart waits seven soft-start periods
// RULE24: Warnings flag only, switching continues
// RULE25: Flags stay until host clears them
`include "fault_supervisor_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module converter_fault_supervisor #(
	parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [15:0] cmdData,
	output var  logic        rspValid,
	output var  logic [15:0] rspData,
	input  wire logic        runRequest,
	input  wire logic [15:0] junctionTemp,
	input  wire logic [15:0] sensorTemp,
	input  wire logic        sensorTempValid,
	input  wire logic        sensorGrounded,
	input  wire logic        overvoltageFault,
	input  wire logic        undervoltageFault,
	input  wire logic        overvoltageWarn,
	input  wire logic        undervoltageWarn,
	output var  logic        switchEnable,
	output var  logic        lowSideOn,
	output var  logic [2:0]  pgHystMultiple,
	output var  logic        powerOkOe,
	output var  logic        alertOe
);
	import fault_supervisor_pkg::*;

	typedef struct packed {
		logic [4:0]    sync1;
		logic [4:0]    sync2;
		seq_state_type st;
		logic [17:0]   tick;
		logic [15:0]   msCnt;
		logic          intHot;
		logic [15:0]   intTrip;
		logic          extHot;
		logic [15:0]   extTrip;
		logic [15:0]   extSample;
		logic [15:0]   faultLimit;
		logic [15:0]   warnLimit;
		logic [15:0]   option_settings;
		logic [15:0]   actions;
		logic [15:0]   maxStartup;
		logic [15:0]   softstart;
		logic [7:0]    tempStatus;
		logic [7:0]    vendorStatus;
		logic [7:0]    alertMask;
		logic [1:0]    scaleLoop;
		logic          rspValid;
		logic [15:0]   rspData;
		logic          switchEn;
		logic          lowSide;
		logic [2:0]    hyst;
		logic          pgOe;
		logic          alertOe;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// Signed compare of two temperature words
	function automatic logic tempAbove(input logic [15:0] a, input logic [15:0] b);
		tempAbove = $signed(a) > $signed(b);
	endfunction : tempAbove

	function automatic fault_action_type actionOf(input logic [15:0] acts, input int lsb);
		actionOf = fault_action_type'(acts[lsb +: 2]);
	endfunction : actionOf

	logic             ovPin;
	logic             uvPin;
	logic             ovWarnPin;
	logic             uvWarnPin;
	logic             groundedPin;
	logic             msPulse;
	logic             sensing;
	logic [15:0]      reading;
	logic             extOver;
	logic             extWarn;
	logic             thermalStop;
	logic             junctionHot;
	logic             faultActive;
	logic [7:0]       tempSet;
	logic [7:0]       vendorSet;
	logic [7:0]       tempClr;
	logic [7:0]       vendorClr;
	logic             wr;
	fault_action_type thAct;
	fault_action_type ovAct;
	fault_action_type uvAct;

	always_comb begin
		state_next = state_reg;
		state_next.sync1 = {sensorGrounded, undervoltageWarn, overvoltageWarn,
			undervoltageFault, overvoltageFault};
		state_next.sync2 = state_reg.sync1;
		ovPin = state_reg.sync2[0];
		uvPin = state_reg.sync2[1];
		ovWarnPin = state_reg.sync2[2];
		uvWarnPin = state_reg.sync2[3];
		groundedPin = state_reg.sync2[4];
		thAct = actionOf(state_reg.actions, `ACT_THERMAL_LSB);
		ovAct = actionOf(state_reg.actions, `ACT_OV_LSB);
		uvAct = actionOf(state_reg.actions, `ACT_UV_LSB);
		wr = cmdValid && cmdWrite;
		tempSet = 8'h00;
		vendorSet = 8'h00;
		tempClr = 8'h00;
		vendorClr = 8'h00;

		// Millisecond tick; wide count so it stays a parameter
		msPulse = state_reg.tick == 18'(MS_CYCLES - 1);
		state_next.tick = msPulse ? 18'h00000 : state_reg.tick + 18'h00001;

		// RULE10: soft-start pin mode
		sensing = state_reg.option_settings[`OPT_SOFTSTART_DETECT_OFF_BIT];
		// RULE6: latest sample kept
		if (sensorTempValid) begin
			state_next.extSample = sensorTemp;
		end
		// RULE9: grounded sensor value
		if (!sensing) begin
			reading = `TEMP_SOFTSTART_MODE;
		end else if (groundedPin) begin
			reading = `TEMP_GROUNDED;
		end else begin
			reading = state_reg.extSample;
		end

		// RULE4: limit comparisons
		extOver = sensing && !groundedPin && tempAbove(reading, state_reg.faultLimit);
		extWarn = sensing && !groundedPin && tempAbove(reading, state_reg.warnLimit);

		// RULE1: internal trip point
		junctionHot = tempAbove(junctionTemp, `SHUTDOWN_TEMPERATURE);
		if (!state_reg.intHot && junctionHot) begin
			state_next.intHot = 1'b1;
			state_next.intTrip = junctionTemp;
		end
		// RULE2: cool by hysteresis
		if (state_reg.intHot
			&& !tempAbove(junctionTemp, state_reg.intTrip - `THERMAL_HYSTERESIS)) begin
			state_next.intHot = 1'b0;
		end
		if (state_reg.intHot) begin
			vendorSet[`VS_INT_THERMAL_BIT] = 1'b1;
		end

		// RULE11: ignore leaves external fault without stop
		if (!state_reg.extHot && extOver && thAct != ACT_IGNORE) begin
			state_next.extHot = 1'b1;
			state_next.extTrip = reading;
		end
		// RULE5: external cool-down
		if (state_reg.extHot && (!sensing || groundedPin
			|| !tempAbove(reading, state_reg.extTrip - `THERMAL_HYSTERESIS))) begin
			state_next.extHot = 1'b0;
		end
		// RULE8: temperature flags
		tempSet[`TEMP_OT_FAULT_BIT] = extOver;
		// RULE24: warning flags only
		tempSet[`TEMP_OT_WARN_BIT] = extWarn;
		vendorSet[`VS_OV_WARN_BIT] = ovWarnPin;
		vendorSet[`VS_UV_WARN_BIT] = uvWarnPin;
		// A hot junction blocks a start in the same cycle, not one later
		thermalStop = state_reg.intHot || state_reg.extHot || junctionHot;

		// RULE18: start-up timer
		if (msPulse && (state_reg.st == ST_START || state_reg.st == ST_HICCUP)) begin
			state_next.msCnt = state_reg.msCnt + 16'h0001;
		end

		unique case (state_reg.st)
			ST_IDLE: begin
				state_next.msCnt = 16'h0000;
				if (runRequest && !thermalStop) begin
					state_next.st = ST_START;
				end
			end
			ST_START, ST_RUN: begin
				if (!runRequest) begin
					state_next.st = ST_IDLE;
				end else if (thermalStop) begin
					// RULE11: latch-off only for external latch setting
					state_next.st = (state_reg.extHot && thAct == ACT_LATCH) ? ST_LATCHED
						: ST_THERMAL;
				// RULE14: ignore leaves switching alone
				end else if (ovPin && ovAct != ACT_IGNORE) begin
					// RULE12: stop and discharge
					state_next.st = ST_DISCHG;
				end else if (state_reg.st == ST_START) begin
					// RULE19: undervoltage judged at max start time
					if (!uvPin && state_reg.msCnt >= state_reg.softstart) begin
						state_next.st = ST_RUN;
					end else if (uvPin && state_reg.msCnt >= state_reg.maxStartup) begin
						vendorSet[`VS_STARTUP_BIT] = 1'b1;
						vendorSet[`VS_UV_FAULT_BIT] = 1'b1;
						// RULE17: ignore keeps running
						if (uvAct == ACT_IGNORE) begin
							state_next.st = ST_RUN;
						end else begin
							state_next.st = (uvAct == ACT_LATCH) ? ST_LATCHED : ST_HICCUP;
							state_next.msCnt = 16'h0000;
						end
					end
				end else if (uvPin) begin
					// RULE16: regulation undervoltage flag
					vendorSet[`VS_UV_FAULT_BIT] = 1'b1;
					// RULE15: both off, wait reset or hiccup
					if (uvAct != ACT_IGNORE) begin
						state_next.st = (uvAct == ACT_LATCH) ? ST_LATCHED : ST_HICCUP;
						state_next.msCnt = 16'h0000;
					end
				end
			end
			ST_DISCHG: begin
				// RULE13: hiccup or latch after discharge
				if (uvPin) begin
					state_next.st = (ovAct == ACT_LATCH) ? ST_LATCHED : ST_HICCUP;
					state_next.msCnt = 16'h0000;
				end
			end
			ST_HICCUP: begin
				// RULE23: seven soft-start periods
				if (!runRequest) begin
					state_next.st = ST_IDLE;
				end else if (!thermalStop
					&& state_reg.msCnt >= 16'(state_reg.softstart * `HICCUP_PERIODS)) begin
					state_next.st = ST_START;
					state_next.msCnt = 16'h0000;
				end
			end
			ST_THERMAL: begin
				if (!runRequest) begin
					state_next.st = ST_IDLE;
				end else if (!thermalStop) begin
					state_next.st = ST_START;
					state_next.msCnt = 16'h0000;
				end
			end
			ST_LATCHED: begin
				// External reset is a drop of the run request
				if (!runRequest) begin
					state_next.st = ST_IDLE;
				end
			end
			default: begin
				state_next.st = ST_IDLE;
			end
		endcase

		// RULE13: overvoltage flag whenever seen
		vendorSet[`VS_OV_FAULT_BIT] = ovPin;

		// RULE7: host programs limits
		state_next.rspValid = cmdValid && !cmdWrite;
		state_next.rspData = 16'h0000;
		if (wr) begin
			unique case (cmdCode)
				`CMD_EXT_TEMP_FAULT_LIMIT: state_next.faultLimit = cmdData;
				`CMD_EXT_TEMP_WARN_LIMIT:  state_next.warnLimit = cmdData;
				`CMD_OPTION_SETTINGS:      state_next.option_settings = cmdData;
				`CMD_FAULT_ACTIONS:        state_next.actions = cmdData;
				`CMD_MAX_STARTUP_TIME:     state_next.maxStartup = cmdData;
				`CMD_SOFTSTART_DURATION:   state_next.softstart = cmdData;
				`CMD_ALERT_MASK:           state_next.alertMask = cmdData[7:0];
				`CMD_SCALE_LOOP:           state_next.scaleLoop = cmdData[1:0];
				`CMD_TEMPERATURE_STATUS:   tempClr = cmdData[7:0];
				`CMD_VENDOR_STATUS:        vendorClr = cmdData[7:0];
				default: begin
				end
			endcase
		end
		if (cmdValid && !cmdWrite) begin
			unique case (cmdCode)
				`CMD_EXT_TEMP_FAULT_LIMIT: state_next.rspData = state_reg.faultLimit;
				`CMD_EXT_TEMP_WARN_LIMIT:  state_next.rspData = state_reg.warnLimit;
				`CMD_OPTION_SETTINGS:      state_next.rspData = state_reg.option_settings;
				`CMD_FAULT_ACTIONS:        state_next.rspData = state_reg.actions;
				`CMD_MAX_STARTUP_TIME:     state_next.rspData = state_reg.maxStartup;
				`CMD_SOFTSTART_DURATION:   state_next.rspData = state_reg.softstart;
				`CMD_ALERT_MASK:           state_next.rspData = {8'h00, state_reg.alertMask};
				`CMD_SCALE_LOOP:           state_next.rspData = {14'h0000, state_reg.scaleLoop};
				`CMD_TEMPERATURE_STATUS:   state_next.rspData = {8'h00, state_reg.tempStatus};
				`CMD_VENDOR_STATUS:        state_next.rspData = {8'h00, state_reg.vendorStatus};
				`CMD_EXT_TEMP_READING:     state_next.rspData = reading;
				default:                   state_next.rspData = 16'h0000;
			endcase
		end

		// RULE25: sticky flags, set beats clear
		state_next.tempStatus = (state_reg.tempStatus & ~tempClr) | tempSet;
		state_next.vendorStatus = (state_reg.vendorStatus & ~vendorClr) | vendorSet;

		// RULE3: unmasked flags drive the alert
		state_next.alertOe = |({state_reg.tempStatus, state_reg.vendorStatus}
			& ~{state_reg.alertMask, state_reg.alertMask});

		// Switch control follows the next state so outputs change with it
		state_next.switchEn = state_next.st == ST_START || state_next.st == ST_RUN;
		state_next.lowSide = state_next.st == ST_DISCHG;

		// RULE21: hysteresis multiple 1, 2, 4 for scale 1, 0.5, 0.25
		unique case (state_reg.scaleLoop)
			2'h1:    state_next.hyst = 3'h2;
			2'h2:    state_next.hyst = 3'h4;
			default: state_next.hyst = 3'h1;
		endcase

		// RULE22: any active fault except undervoltage or external over-temperature under ignore pulls low
		faultActive = thermalStop || ovPin || (extOver && thAct != ACT_IGNORE)
			|| !(state_reg.st inside {ST_START, ST_RUN});
		// RULE20: released only in window after start-up
		state_next.pgOe = !(state_reg.st == ST_RUN && !faultActive && !ovWarnPin && !uvWarnPin);
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= '{
				sync1: 5'h00, sync2: 5'h00, st: ST_IDLE, tick: 18'h00000,
				msCnt: 16'h0000, intHot: 1'b0, intTrip: 16'h0000,
				extHot: 1'b0, extTrip: 16'h0000, extSample: 16'h0000,
				faultLimit: `RST_EXT_FAULT_LIMIT, warnLimit: `RST_EXT_WARN_LIMIT,
				option_settings: `RST_OPTION_SETTINGS, actions: `RST_ACTIONS,
				maxStartup: `RST_MAX_STARTUP, softstart: `RST_SOFTSTART,
				tempStatus: 8'h00, vendorStatus: 8'h00, alertMask: `RST_ALERT_MASK,
				scaleLoop: `RST_SCALE_LOOP, rspValid: 1'b0, rspData: 16'h0000,
				switchEn: 1'b0, lowSide: 1'b0, hyst: 3'h1, pgOe: 1'b1, alertOe: 1'b0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	assign rspValid = state_reg.rspValid;
	assign rspData = state_reg.rspData;
	assign switchEnable = state_reg.switchEn;
	assign lowSideOn = state_reg.lowSide;
	assign pgHystMultiple = state_reg.hyst;
	assign powerOkOe = state_reg.pgOe;
	assign alertOe = state_reg.alertOe;
endmodule : converter_fault_supervisor

`default_nettype wire

/* File: shared/fault_supervisor_cfg.svh */
// Purpose: Command codes, field positions, reset values and limits of the fault supervisor
// Assumes: Temperatures are signed 16-bit whole degrees C
// Notes:   Definitions only
`ifndef FAULT_SUPERVISOR_CFG_SVH
`define FAULT_SUPERVISOR_CFG_SVH

`define CMD_EXT_TEMP_FAULT_LIMIT 8'h4F
`define CMD_EXT_TEMP_WARN_LIMIT  8'h51
`define CMD_TEMPERATURE_STATUS   8'h7D
`define CMD_EXT_TEMP_READING     8'h8E
`define CMD_OPTION_SETTINGS      8'hE5
`define CMD_FAULT_ACTIONS        8'hD0
`define CMD_MAX_STARTUP_TIME     8'hD1
`define CMD_SOFTSTART_DURATION   8'hD2
`define CMD_VENDOR_STATUS        8'hD3
`define CMD_ALERT_MASK           8'hD4
`define CMD_SCALE_LOOP           8'hD5

`define TEMP_OT_FAULT_BIT 7
`define TEMP_OT_WARN_BIT  6

`define VS_INT_THERMAL_BIT 0
`define VS_OV_FAULT_BIT    1
`define VS_UV_FAULT_BIT    2
`define VS_OV_WARN_BIT     3
`define VS_UV_WARN_BIT     4
`define VS_STARTUP_BIT     5

`define OPT_SOFTSTART_DETECT_OFF_BIT 0

`define ACT_THERMAL_LSB 0
`define ACT_OV_LSB      2
`define ACT_UV_LSB      4

`define RST_EXT_FAULT_LIMIT 16'h007D
`define RST_EXT_WARN_LIMIT  16'h0064
`define RST_OPTION_SETTINGS         16'h0001
`define RST_ACTIONS         16'h0015
`define RST_MAX_STARTUP     16'h0032
`define RST_SOFTSTART       16'h0005
`define RST_ALERT_MASK      8'h00
`define RST_SCALE_LOOP      2'h0

`define SHUTDOWN_TEMPERATURE 16'h0091
`define THERMAL_HYSTERESIS   16'h0014
`define TEMP_GROUNDED        16'hFFD8
`define TEMP_SOFTSTART_MODE  16'h0019
`define HICCUP_PERIODS       3'h7

`define CLOCK_MHZ     200
`define MS_IN_US      1000
`define MS_CYCLES_DEF (`CLOCK_MHZ * `MS_IN_US)

`endif

/* File: shared/fault_supervisor_pkg.sv */
// Purpose: Types of the fault supervisor
// Assumes: One-hot sequencer states
// Notes:   Codes live in fault_supervisor_cfg.svh
package fault_supervisor_pkg;
	typedef enum logic [6:0] {
		ST_IDLE    = 7'h01,
		ST_START   = 7'h02,
		ST_RUN     = 7'h04,
		ST_DISCHG  = 7'h08,
		ST_HICCUP  = 7'h10,
		ST_THERMAL = 7'h20,
		ST_LATCHED = 7'h40
	} seq_state_type;

	typedef enum logic [1:0] {
		ACT_LATCH   = 2'h0,
		ACT_RESTART = 2'h1,
		ACT_IGNORE  = 2'h2,
		ACT_RSVD    = 2'h3
	} fault_action_type;
endpackage : fault_supervisor_pkg
